// *** inc/cic_gain_decimation_control_cfg.svh ***
/*
  Offsets, field positions, reset values and widths of the CIC gain and
  decimation control block. Assumes it is included by bare name.
*/
`ifndef CIC_GAIN_DECIMATION_CONTROL_CFG_SVH
`define CIC_GAIN_DECIMATION_CONTROL_CFG_SVH

// ****************************************************************
// register map (byte addresses, 32-bit aligned words)
// ****************************************************************
`define ADDR_W 8
`define CTRL_OFS 8'h00
`define STATUS_OFS 8'h04

// ****************************************************************
// control word fields
// ****************************************************************
`define BYPASS_BIT 6
`define DEC_LSB 7
`define DEC_MSB 12
`define SG_LSB 13
`define SG_MSB 16
`define SYNC_EN_BIT 19
`define CTRL_MASK 32'h0009_ffc0
`define CTRL_RST 32'h0001_e180

// ****************************************************************
// status word fields
// ****************************************************************
`define ST_CNT_LSB 0
`define ST_SHIFT_LSB 8

// ****************************************************************
// datapath widths
// ****************************************************************
`define SHIFT_MAX 5'h0f
`define IN_W 15
`define ACC_W 40
`define OUT_W 32
`define STAGES 5
`define ACC_W0 40
`define ACC_W1 36
`define ACC_W2 32
`define ACC_W3 32
`define ACC_W4 32

`endif

// *** inc/cic_gain_decimation_control_pkg.sv ***
/*
  Types shared by the CIC gain and decimation control files.
  Assumes the cfg header is available on the include path.
*/
`include "cic_gain_decimation_control_cfg.svh"

package cic_gain_decimation_control_pkg;
  typedef logic signed [`IN_W-1:0] sample_t;
  typedef logic signed [`ACC_W-1:0] acc_t;
  typedef logic signed [`OUT_W-1:0] cic_word_t;
  typedef logic [3:0] shift_t;
  typedef logic [5:0] dec_rate_t;
  typedef logic [2:0] gain_step_t;
  typedef logic [1:0] axi_resp_t;
endpackage : cic_gain_decimation_control_pkg

// *** rtl/cic_decimation_counter.sv ***
/*
  Decimation counter: counts samples down from R-1 and marks the
  sample that completes an output. External sync reloads it.
  Assumes external_sync_in is synchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cic_gain_decimation_control_cfg.svh"

module cic_decimation_counter
  import cic_gain_decimation_control_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic sample_valid,
  input wire dec_rate_t dec_rate,
  input wire logic sync_en,
  input wire logic external_sync_in,
  // state
  output logic dump,
  output dec_rate_t count_q
);
  logic sync_prev_q;
  logic sync_hit;

  assign sync_hit = sync_en && external_sync_in && !sync_prev_q;
  assign dump = sample_valid && count_q == '0 && !sync_hit;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_prev_q <= 1'b0;
    end else begin
      sync_prev_q <= external_sync_in;
    end
  end

  // sync reload wins over a coincident sample
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (sync_hit) begin
      count_q <= dec_rate;
    end else if (sample_valid) begin
      count_q <= (count_q == '0) ? dec_rate : count_q - 6'h01;
    end
  end

  a_sync_reload: assert property (@(posedge core_clk) disable iff (rst)
    sync_en && external_sync_in && !sync_prev_q
    |=> count_q == $past(dec_rate) && (count_q == '0 || !dump))
    else $error("sync did not restart the decimation count");
  a_sync_ignored: assert property (@(posedge core_clk) disable iff (rst)
    !sync_en && !sample_valid |=> $stable(count_q))
    else $error("count moved without a sample");
  a_dump_after_r: assert property (@(posedge core_clk) disable iff (rst)
    sync_hit && dec_rate > 6'h01 ##2 (sample_valid && !sync_hit) |-> !dump)
    else $error("output came before R samples after sync");
endmodule : cic_decimation_counter
`default_nettype wire

// *** rtl/cic_gain_decimation_control.sv ***
/*
  Gain and decimation control of a fifth order CIC decimator with its
  integrator and comb chain, programmed over an AXI4-Lite slave.
  Assumes one clock, samples and pins synchronous to core_clk, and a
  master with at most one write and one read outstanding.
*/
// Decided for this implementation: the address map and register access over AXI4-Lite.
// How it works
// - 4-bit shift gain 0 to 15 shifts the input one bit per step
// - decimation rate is a 6-bit field holding R minus one
// - each gain step code adds 6dB at the filter input
// - with sync enabled, the sync pin reloads the decimation counter
// - shift is the sum of shift gain and gain step, saturated at 15
// - gain step is pipelined alongside its own sample
// - integrators are 40, 36, 32, 32 and 32 bits wide
// - decimation rate sits in control bits 12 to 7
`timescale 1ns/1ps
`default_nettype none
`include "cic_gain_decimation_control_cfg.svh"

module cic_gain_decimation_control
  import cic_gain_decimation_control_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic [`ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output axi_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [`ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output axi_resp_t rresp,
  output logic rvalid,
  input wire logic rready,
  // mixer samples and front end pins
  input wire sample_t sample_in,
  input wire logic sample_valid,
  input wire gain_step_t input_gain_step,
  input wire logic external_sync_in,
  // filter output
  output cic_word_t cic_out_q,
  output logic cic_valid_q
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  logic aw_hold_q;
  logic [`ADDR_W-1:0] aw_addr_q;
  logic w_hold_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  axi_resp_t bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  axi_resp_t rresp_q;
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic do_write;
  logic [31:0] status;
  shift_t coarse_shift_gain;
  dec_rate_t dec_rate;
  logic bypass;
  logic sync_en;
  acc_t shifted_q;
  logic shifted_valid_q;
  shift_t shift_q;
  logic dump;
  dec_rate_t count_q;
  acc_t acc_q [`STAGES];
  acc_t stg_in [`STAGES];
  cic_word_t comb_in [`STAGES+1];
  cic_word_t comb_dly_q [`STAGES];

  // ****************************************************************
  // control fields
  // ****************************************************************
  assign dec_rate = ctrl_q[`DEC_MSB:`DEC_LSB];
  assign coarse_shift_gain = ctrl_q[`SG_MSB:`SG_LSB];
  assign bypass = ctrl_q[`BYPASS_BIT];
  assign sync_en = ctrl_q[`SYNC_EN_BIT];

  always_comb begin
    status = '0;
    status[`ST_CNT_LSB +: 6] = count_q;
    status[`ST_SHIFT_LSB +: 4] = shift_q;
  end

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  assign awready = !aw_hold_q && !bvalid_q;
  assign wready = !w_hold_q && !bvalid_q;
  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (do_write) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      w_hold_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid && wready) begin
      w_hold_q <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (do_write) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (aw_addr_q == `CTRL_OFS || aw_addr_q == `STATUS_OFS) ? 2'h0 : 2'h2;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // byte lanes merge into the control word; unused bits stay zero
  always_comb begin
    ctrl_d = ctrl_q;
    for (int b = 0; b < 4; b++) begin
      if (w_strb_q[b]) begin
        ctrl_d[8*b +: 8] = w_data_q[8*b +: 8];
      end
    end
    ctrl_d = ctrl_d & `CTRL_MASK;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `CTRL_RST;
    end else if (do_write && aw_addr_q == `CTRL_OFS) begin
      ctrl_q <= ctrl_d;
    end
  end

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= 2'h0;
      case (araddr)
        `CTRL_OFS: rdata_q <= ctrl_q;
        `STATUS_OFS: rdata_q <= status;
        default: begin
          rdata_q <= '0;
          rresp_q <= 2'h2;
        end
      endcase
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************************************
  // input shifter and decimation counter
  // ****************************************************************
  cic_input_shifter u_shifter (
    .core_clk(core_clk),
    .rst(rst),
    .sample_in(sample_in),
    .sample_valid(sample_valid),
    .input_gain_step(input_gain_step),
    .coarse_shift_gain(coarse_shift_gain),
    .shifted_q(shifted_q),
    .shifted_valid_q(shifted_valid_q),
    .shift_q(shift_q)
  );

  cic_decimation_counter u_counter (
    .core_clk(core_clk),
    .rst(rst),
    .sample_valid(shifted_valid_q),
    .dec_rate(dec_rate),
    .sync_en(sync_en),
    .external_sync_in(external_sync_in),
    .dump(dump),
    .count_q(count_q)
  );

  // ****************************************************************
  // integrators
  // ****************************************************************
  function automatic int stage_w(input int i);
    case (i)
      0: stage_w = `ACC_W0;
      1: stage_w = `ACC_W1;
      2: stage_w = `ACC_W2;
      3: stage_w = `ACC_W3;
      default: stage_w = `ACC_W4;
    endcase
  endfunction : stage_w

  // keep the low w bits, sign extended, as a narrower adder would
  function automatic acc_t wrap(input acc_t x, input int w);
    wrap = (x <<< (`ACC_W - w)) >>> (`ACC_W - w);
  endfunction : wrap

  for (genvar i = 0; i < `STAGES; i++) begin : g_integ
    if (i == 0) begin : g_first
      assign stg_in[i] = shifted_q;
    end else begin : g_next
      assign stg_in[i] = wrap(acc_q[i-1] >>> (stage_w(i-1) - stage_w(i)), stage_w(i));
    end
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        acc_q[i] <= '0;
      end else if (shifted_valid_q) begin
        acc_q[i] <= wrap(acc_q[i] + stg_in[i], stage_w(i));
      end
    end
  end

  // ****************************************************************
  // combs at the decimated rate
  // ****************************************************************
  assign comb_in[0] = acc_q[`STAGES-1][`OUT_W-1:0];

  for (genvar i = 0; i < `STAGES; i++) begin : g_comb
    assign comb_in[i+1] = comb_in[i] - comb_dly_q[i];
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        comb_dly_q[i] <= '0;
      end else if (dump) begin
        comb_dly_q[i] <= comb_in[i];
      end
    end
  end

  // bypass passes every shifted sample straight on
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cic_out_q <= '0;
      cic_valid_q <= 1'b0;
    end else if (bypass) begin
      cic_valid_q <= shifted_valid_q;
      if (shifted_valid_q) begin
        cic_out_q <= shifted_q[`OUT_W-1:0];
      end
    end else begin
      cic_valid_q <= dump;
      if (dump) begin
        cic_out_q <= comb_in[`STAGES];
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_rate_field: assert property (@(posedge core_clk) disable iff (rst)
    do_write && aw_addr_q == `CTRL_OFS && w_strb_q[1] && w_strb_q[0]
    |=> dec_rate == $past(w_data_q[12:7]))
    else $error("decimation rate not taken from bits 12 to 7");
  a_acc_width: assert property (@(posedge core_clk) disable iff (rst)
    shifted_valid_q |=> acc_q[1] == wrap(acc_q[1], 36) && acc_q[2] == wrap(acc_q[2], 32))
    else $error("integrator exceeds its width");
  a_acc_sum: assert property (@(posedge core_clk) disable iff (rst)
    shifted_valid_q |=> acc_q[0] == $past(acc_q[0]) + $past(shifted_q))
    else $error("first integrator did not add the shifted sample");
  a_out_on_dump: assert property (@(posedge core_clk) disable iff (rst)
    !bypass && dump |=> cic_valid_q && cic_out_q == $past(comb_in[5]))
    else $error("decimated output missed its dump");
endmodule : cic_gain_decimation_control
`default_nettype wire

// *** rtl/cic_input_shifter.sv ***
/*
  Barrel shifter ahead of the first integrator: coarse shift plus
  gain step, saturated, registered together with the sample.
  Assumes sample and gain step pins are synchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cic_gain_decimation_control_cfg.svh"

module cic_input_shifter
  import cic_gain_decimation_control_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // sample in
  input wire sample_t sample_in,
  input wire logic sample_valid,
  input wire gain_step_t input_gain_step,
  input wire shift_t coarse_shift_gain,
  // shifted sample out
  output acc_t shifted_q,
  output logic shifted_valid_q,
  output shift_t shift_q
);
  logic [4:0] sum;
  shift_t shift_d;

  // ****************************************************************
  // saturating gain sum
  // ****************************************************************
  always_comb begin
    sum = {1'b0, coarse_shift_gain} + {2'b00, input_gain_step};
    shift_d = (sum > `SHIFT_MAX) ? 4'hf : sum[3:0];
  end

  // gain step is captured with its own sample
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shifted_q <= '0;
      shifted_valid_q <= 1'b0;
      shift_q <= '0;
    end else begin
      shifted_valid_q <= sample_valid;
      if (sample_valid) begin
        shift_q <= shift_d;
        shifted_q <= acc_t'(sample_in) <<< shift_d;
      end
    end
  end

  a_shift_sum: assert property (@(posedge core_clk) disable iff (rst)
    sample_valid |=> shift_q == (($past(coarse_shift_gain) + $past(input_gain_step) > 15)
      ? 4'hf : $past(coarse_shift_gain) + $past(input_gain_step)))
    else $error("shift amount not the saturated sum");
  a_shift_apply: assert property (@(posedge core_clk) disable iff (rst)
    sample_valid ##1 shifted_valid_q |-> shifted_q == (acc_t'($past(sample_in)) <<< shift_q))
    else $error("sample not shifted by the registered amount");
  a_step_aligned: assert property (@(posedge core_clk) disable iff (rst)
    sample_valid && coarse_shift_gain == 4'h0 |=> shift_q == {1'b0, $past(input_gain_step)})
    else $error("gain step not applied to its own sample");
endmodule : cic_input_shifter
`default_nettype wire

// *** verification/cic_gain_decimation_control_tb_top.sv ***
/*
  Self-checking bench: AXI4-Lite register access, bypass gain path and
  decimation counter with and without external sync.
  Assumes the design package, cfg header and front end model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cic_gain_decimation_control_cfg.svh"

module cic_gain_decimation_control_tb_top
  import cic_gain_decimation_control_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0, wr_strb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, cic_valid_q;
  axi_resp_t bresp, rresp, b_c, r_c;
  logic [31:0] rdata, rd_c;
  sample_t sample_in;
  logic sample_valid, external_sync_in;
  gain_step_t input_gain_step;
  cic_word_t cic_out_q, last_out;
  dec_rate_t cur_dec = 6'h03;
  logic aw_t = 1'b0, w_t = 1'b0, b_t = 1'b0, ar_t = 1'b0, r_t = 1'b0;
  int n_out = 0, n_mismatch = 0, n_compared = 0, cyc = 0;

  always #50 core_clk = ~core_clk;

  cic_gain_decimation_control dut_u (
    .core_clk(core_clk), .rst(rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sample_in(sample_in), .sample_valid(sample_valid),
    .input_gain_step(input_gain_step), .external_sync_in(external_sync_in),
    .cic_out_q(cic_out_q), .cic_valid_q(cic_valid_q)
  );

  front_end_model fe_u (
    .core_clk(core_clk), .dec_rate(cur_dec), .sample_in(sample_in),
    .sample_valid(sample_valid), .input_gain_step(input_gain_step),
    .external_sync_in(external_sync_in)
  );

  // handshakes and outputs as seen at each rising edge
  always @(posedge core_clk) begin
    aw_t <= awvalid && awready;
    w_t <= wvalid && wready;
    b_t <= bvalid && bready;
    b_c <= bresp;
    ar_t <= arvalid && arready;
    r_t <= rvalid && rready;
    r_c <= rresp;
    rd_c <= rdata;
    if (cic_valid_q === 1'b1) begin
      n_out <= n_out + 1;
      last_out <= cic_out_q;
    end
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output axi_resp_t r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= wr_strb;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge core_clk);
      #1;
      if (aw_t) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (w_t) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!b_t) begin
      @(posedge core_clk);
      #1;
    end
    r = b_c;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output axi_resp_t r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      #1;
      if (ar_t) arvalid <= 1'b0;
    end while (!r_t);
    d = rd_c;
    r = r_c;
  endtask : axi_read

  function automatic logic [31:0] ctrl(input logic se, input shift_t sg,
                                       input dec_rate_t dr, input logic by);
    ctrl = 32'h0;
    ctrl[`SYNC_EN_BIT] = se;
    ctrl[`SG_MSB:`SG_LSB] = sg;
    ctrl[`DEC_MSB:`DEC_LSB] = dr;
    ctrl[`BYPASS_BIT] = by;
  endfunction : ctrl

  task automatic feed(input sample_t s, input gain_step_t g, output logic [31:0] n);
    int base;
    base = n_out;
    fe_u.send(s, g);
    repeat (3) @(posedge core_clk);
    #1;
    n = n_out - base;
  endtask : feed

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    logic [31:0] d, n;
    axi_resp_t r;
    acc_t e;
    shift_t sg;
    int sh, rr;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    axi_read(`CTRL_OFS, d, r);
    chk("ctrl reset", d, `CTRL_RST);
    axi_write(`CTRL_OFS, 32'hffff_ffff, r);
    chk("write resp", {30'h0, r}, 32'h0);
    axi_read(`CTRL_OFS, d, r);
    chk("ctrl mask", d, `CTRL_MASK);
    wr_strb = 4'h1;
    axi_write(`CTRL_OFS, 32'h0, r);
    wr_strb = 4'hf;
    axi_write(8'h08, 32'h0, r);
    chk("unmapped wr resp", {30'h0, r}, 32'h2);
    axi_write(`STATUS_OFS, 32'h0, r);
    chk("status wr resp", {30'h0, r}, 32'h0);
    axi_read(`CTRL_OFS, d, r);
    chk("ctrl strobe", d, `CTRL_MASK & 32'hffff_ff00);
    axi_read(8'h08, d, r);
    chk("unmapped resp", {30'h0, r}, 32'h2);
    chk("unmapped data", d, 32'h0);
    $display("test registers done");

    for (int g = 0; g < 8; g++) begin
      axi_write(`CTRL_OFS, ctrl(1'b0, shift_t'(2 * g), 6'h03, 1'b1), r);
      feed(15'h7ffd, gain_step_t'(g), n);
      sh = 3 * g;
      if (sh > 15) sh = 15;
      e = acc_t'(sample_t'(15'h7ffd));
      e = e <<< sh;
      chk("bypass count", n, 32'h1);
      chk("bypass out", last_out, e[31:0]);
      axi_read(`STATUS_OFS, d, r);
      chk("status shift", {28'h0, d[11:8]}, 32'(sh));
    end
    $display("test gain done");

    for (int k = 0; k < 2; k++) begin
      rr = (k == 0) ? 4 : 7;
      cur_dec = dec_rate_t'(rr - 1);
      sg = fe_u.pick_shift((k == 0) ? 14 : 12, rr);
      axi_write(`CTRL_OFS, ctrl(1'b1, sg, cur_dec, 1'b0), r);
      fe_u.sync_pulse();
      for (int i = 1; i <= 2 * rr; i++) begin
        feed(15'h0001, 3'h0, n);
        chk("synced out", n, 32'((i % rr) == 0));
      end
      axi_read(`STATUS_OFS, d, r);
      chk("status sg", {28'h0, d[11:8]}, 32'(sg));
      axi_write(`CTRL_OFS, ctrl(1'b0, sg, cur_dec, 1'b0), r);
      feed(15'h0001, 3'h0, n);
      chk("free out", n, 32'h0);
      fe_u.sync_pulse();
      for (int i = 2; i <= rr; i++) begin
        feed(15'h0001, 3'h0, n);
        chk("free out", n, 32'(i == rr));
      end
    end
    $display("test decimation done");
    tally_and_finish();
  end
endmodule : cic_gain_decimation_control_tb_top

`default_nettype wire

// *** verification/front_end_model.sv ***
/*
  Front end model: mixer samples, gain step pins and the sync pin.
  Assumes its tasks are entered just after a rising core_clk edge.
*/
`timescale 1ns/1ps
`default_nettype none

module front_end_model
  import cic_gain_decimation_control_pkg::*;
(
  // clock and rate in use
  input wire logic core_clk,
  input wire dec_rate_t dec_rate,
  // pins toward the filter
  output sample_t sample_in,
  output logic sample_valid,
  output gain_step_t input_gain_step,
  output logic external_sync_in
);
  initial begin
    sample_in = '0;
    sample_valid = 1'b0;
    input_gain_step = '0;
    external_sync_in = 1'b0;
  end

  // ****************************************************************
  // one sample for one cycle; idle lines show the inverse afterwards
  // ****************************************************************
  task automatic send(input sample_t s, input gain_step_t g);
    sample_in <= s;
    sample_valid <= 1'b1;
    input_gain_step <= (dec_rate == 6'h1f) ? 3'h0 : g;
    @(posedge core_clk);
    #1;
    sample_valid <= 1'b0;
    sample_in <= ~s;
    input_gain_step <= ~g;
  endtask : send

  task automatic sync_pulse();
    external_sync_in <= 1'b1;
    @(posedge core_clk);
    #1;
    external_sync_in <= 1'b0;
  endtask : sync_pulse

  // ****************************************************************
  // coarse shift gain that software picks for its input resolution
  // ****************************************************************
  function automatic shift_t pick_shift(input int bits, input int r);
    int c, lo;
    c = 39 - bits;
    lo = (bits >= 14) ? 4 : (bits >= 12) ? 5 : (bits >= 10) ? 6 : 9;
    pick_shift = (r <= lo) ? 4'hf : shift_t'(c - $clog2(r ** 5));
  endfunction : pick_shift
endmodule : front_end_model

`default_nettype wire
